// ---- smc_pkg.sv ----
package smc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_SRC = 8;
    localparam int unsigned NUM_PINS = 8;

    // Wake-capable interrupt source positions
    localparam int unsigned SRC_TIMER_ONE = 0;
    localparam int unsigned SRC_SERIAL_RX = 1;
    localparam int unsigned SRC_ADC_RC = 2;
    localparam int unsigned SRC_PIN_CHANGE = 3;
    localparam int unsigned SRC_EXT_PIN = 4;
    localparam int unsigned SRC_CAPTURE_A = 5;
    localparam int unsigned SRC_CAPTURE_B = 6;
    localparam int unsigned SRC_SYNC_SERIAL = 7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned OSC_PERIOD_PS = 4000;
    localparam int unsigned OST_OSC_PERIODS = 1024;
    localparam int unsigned OST_CYCLES =
        (OST_OSC_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned OST_W = 11;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_PD_N = 1'b1;
    localparam logic RST_TO_N = 1'b1;
    localparam logic [7:0] RST_PINS = 8'h00;

    // ------------------------------------------------------------
    // Controller states, Gray along run-sleep-start-up-resume
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_OST = 2'b11,
        ST_RESUME = 2'b10
    } smc_state_t;

endpackage : smc_pkg

// ---- smc_wake_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface smc_wake_if;
    logic [smc_pkg::NUM_SRC-1:0] flag;
    logic [smc_pkg::NUM_SRC-1:0] enable;
    logic [smc_pkg::NUM_SRC-1:0] clock_free;
    logic asleep;
    logic pend_any;
    logic wake_any;
    modport ctrl (output flag, output enable, output clock_free, output asleep,
                  input pend_any, input wake_any);
    modport merge (input flag, input enable, input clock_free, input asleep,
                   output pend_any, output wake_any);
endinterface : smc_wake_if
`default_nettype wire

// ---- smc_wake_merge.sv ----
`timescale 1ns/1ps
`default_nettype none
module smc_wake_merge (
    smc_wake_if.merge w
);
    logic [smc_pkg::NUM_SRC-1:0] live;

    // During sleep only sources that run without on-chip clocks may fire
    assign live = w.asleep ? (w.flag & w.clock_free) : w.flag; // [R11] [R10]
    assign w.pend_any = |(w.flag & w.enable); // [R16] [R19]
    assign w.wake_any = |(live & w.enable); // [R13]
endmodule : smc_wake_merge
`default_nettype wire

// ---- smc_ost_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module smc_ost_timer (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic run,
    output logic done
);
    logic [smc_pkg::OST_W-1:0] cnt_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (!done) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign done = (cnt_q == smc_pkg::OST_W'(smc_pkg::OST_CYCLES - 1)); // [R20]
endmodule : smc_ost_timer
`default_nettype wire

// ---- smc_sleep_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] Sleep is entered only when the core executes the sleep instruction.
// [R2] Sleep entry with watchdog enabled clears its count; it keeps running.
// [R3] Sleep entry clears the power-down flag and sets the time-out flag.
// [R4] Main oscillator driver is off in sleep; timer-one oscillator unaffected.
// [R5] Every pin holds its pre-sleep drive state throughout sleep.
// [R6] A watchdog time-out reset never drives the master-clear pin low.
// [R7] Wake by master-clear, watchdog time-out or interrupt; master-clear fully resets.
// [R8] Watchdog or interrupt wake resumes execution without a reset.
// [R9] Power-down flag set at power-up; time-out flag cleared on watchdog wake.
// [R10] Only the listed clock-free peripheral interrupts may wake the device.
// [R11] No other peripheral interrupt is raised during sleep.
// [R12] The next instruction is prefetched while sleep executes.
// [R13] Interrupt wakes only if individually enabled, regardless of global enable.
// [R14] Global enable set: run next instruction, then branch to the vector.
// [R15] Software should put a no-operation after sleep when needed.
// [R16] A pending enabled interrupt during sleep entry wakes at once.
// [R17] The watchdog count is cleared on every wake-up; here only on watchdog or interrupt wake, not master clear.
// [R18] The external circuit holds master-clear high during sleep.
// [R19] Pending enabled interrupt before sleep makes sleep a no-operation.
// [R20] Wait 1024 oscillator periods after restart, except external or RC clock.
module smc_sleep_ctrl (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sleep_exec,
    input wire logic wdt_enable,
    input wire logic wdt_timeout,
    input wire logic master_clear_pin_n,
    input wire logic global_irq_enable,
    input wire logic [smc_pkg::NUM_SRC-1:0] irq_flag,
    input wire logic [smc_pkg::NUM_SRC-1:0] irq_enable,
    input wire logic [smc_pkg::NUM_SRC-1:0] irq_clock_free,
    input wire logic osc_no_startup,
    input wire logic sec_osc_request,
    input wire logic [smc_pkg::NUM_PINS-1:0] pin_out_core,
    input wire logic [smc_pkg::NUM_PINS-1:0] pin_oe_core,
    output logic power_down_flag_n,
    output logic timeout_flag_n,
    output logic watchdog_clear,
    output logic main_osc_enable,
    output logic sec_osc_enable,
    output logic core_halt,
    output logic prefetch_next,
    output logic sleep_as_nop,
    output logic core_resume,
    output logic branch_to_vector,
    output logic device_reset,
    output logic wdt_reset,
    output logic master_clear_oe,
    output logic [smc_pkg::NUM_PINS-1:0] pin_out,
    output logic [smc_pkg::NUM_PINS-1:0] pin_oe
);

    // ------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------
    smc_pkg::smc_state_t state_q;
    logic pd_n_q;
    logic to_n_q;
    logic wdt_clr_q;
    logic osc_en_q;
    logic sec_osc_q;
    logic hold_q;
    logic prefetch_q;
    logic nop_q;
    logic resume_q;
    logic branch_q;
    logic dev_rst_q;
    logic wdt_rst_q;
    logic master_clear_pin_n_oe_q;
    logic irq_wake_q;
    logic [smc_pkg::NUM_PINS-1:0] pin_out_q;
    logic [smc_pkg::NUM_PINS-1:0] pin_oe_q;
    logic ost_done;
    logic wdt_wake;
    logic wake_evt;
    logic master_clear_pin_n_low;
    logic enter;

    smc_wake_if wif ();

    assign wif.flag = irq_flag;
    assign wif.enable = irq_enable;
    assign wif.clock_free = irq_clock_free;
    assign wif.asleep = (state_q == smc_pkg::ST_SLEEP);

    smc_wake_merge u_merge (
        .w(wif.merge)
    );

    smc_ost_timer u_ost (
        .clock(clock),
        .rst_b(rst_b),
        .run(state_q == smc_pkg::ST_OST),
        .done(ost_done)
    );

    assign master_clear_pin_n_low = !master_clear_pin_n;
    assign wdt_wake = wdt_enable && wdt_timeout;
    assign wake_evt = wif.wake_any || wdt_wake;
    assign enter = (state_q == smc_pkg::ST_RUN) && sleep_exec && !wif.pend_any && !master_clear_pin_n_low;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= smc_pkg::ST_RUN;
        end else if (master_clear_pin_n_low) begin
            state_q <= smc_pkg::ST_RUN; // [R7]
        end else begin
            case (state_q)
                smc_pkg::ST_RUN: begin
                    if (enter) begin
                        state_q <= smc_pkg::ST_SLEEP; // [R1]
                    end
                end
                smc_pkg::ST_SLEEP: begin
                    if (wake_evt) begin
                        state_q <= osc_no_startup ? smc_pkg::ST_RESUME : smc_pkg::ST_OST; // [R20]
                    end
                end
                smc_pkg::ST_OST: begin
                    if (ost_done) begin
                        state_q <= smc_pkg::ST_RESUME; // [R20]
                    end
                end
                smc_pkg::ST_RESUME: begin
                    state_q <= smc_pkg::ST_RUN; // [R8]
                end
                default: begin
                    state_q <= smc_pkg::ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pd_n_q <= smc_pkg::RST_PD_N; // [R9]
            to_n_q <= smc_pkg::RST_TO_N;
        end else if (enter) begin
            pd_n_q <= 1'b0; // [R3] [R9]
            to_n_q <= 1'b1; // [R3]
        end else if (!master_clear_pin_n_low && wdt_wake &&
                     (state_q == smc_pkg::ST_SLEEP || state_q == smc_pkg::ST_RUN)) begin
            to_n_q <= 1'b0; // [R9]
        end
    end

    // ------------------------------------------------------------
    // Watchdog clear and resets
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wdt_clr_q <= 1'b0;
        end else begin
            // Cleared on entry when enabled, and on any watchdog or interrupt wake (not on master clear)
            wdt_clr_q <= (enter && wdt_enable) || // [R2]
                         (state_q == smc_pkg::ST_SLEEP && wake_evt && !master_clear_pin_n_low); // [R17]
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dev_rst_q <= 1'b0;
            wdt_rst_q <= 1'b0;
            master_clear_pin_n_oe_q <= 1'b0;
        end else begin
            dev_rst_q <= master_clear_pin_n_low; // [R7]
            // Time-out out of sleep is a wake, only a running time-out resets
            wdt_rst_q <= wdt_wake && state_q == smc_pkg::ST_RUN && !master_clear_pin_n_low; // [R8]
            master_clear_pin_n_oe_q <= 1'b0; // [R6]
        end
    end

    // ------------------------------------------------------------
    // Oscillators
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            osc_en_q <= 1'b1;
        end else if (master_clear_pin_n_low) begin
            osc_en_q <= 1'b1;
        end else if (enter) begin
            osc_en_q <= 1'b0; // [R4]
        end else if (state_q == smc_pkg::ST_SLEEP && wake_evt) begin
            osc_en_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sec_osc_q <= 1'b0;
        end else begin
            sec_osc_q <= sec_osc_request; // [R4]
        end
    end

    // ------------------------------------------------------------
    // Pin hold
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hold_q <= 1'b0;
        end else if (master_clear_pin_n_low || state_q == smc_pkg::ST_RESUME) begin
            hold_q <= 1'b0;
        end else if (enter) begin
            hold_q <= 1'b1; // [R5]
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_out_q <= smc_pkg::RST_PINS;
            pin_oe_q <= smc_pkg::RST_PINS;
        end else if (!hold_q) begin
            pin_out_q <= pin_out_core; // [R5]
            pin_oe_q <= pin_oe_core;
        end
    end

    // ------------------------------------------------------------
    // Core handshake
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prefetch_q <= 1'b0;
            nop_q <= 1'b0;
        end else begin
            prefetch_q <= state_q == smc_pkg::ST_RUN && sleep_exec && !master_clear_pin_n_low; // [R12]
            nop_q <= state_q == smc_pkg::ST_RUN && sleep_exec &&
                     wif.pend_any && !master_clear_pin_n_low; // [R19]
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_wake_q <= 1'b0;
        end else if (state_q == smc_pkg::ST_SLEEP && wake_evt) begin
            irq_wake_q <= wif.wake_any;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            resume_q <= 1'b0;
            branch_q <= 1'b0;
        end else begin
            resume_q <= state_q == smc_pkg::ST_RESUME && !master_clear_pin_n_low; // [R8]
            branch_q <= state_q == smc_pkg::ST_RESUME && !master_clear_pin_n_low &&
                        irq_wake_q && global_irq_enable; // [R14]
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign power_down_flag_n = pd_n_q;
    assign timeout_flag_n = to_n_q;
    assign watchdog_clear = wdt_clr_q;
    assign main_osc_enable = osc_en_q;
    assign sec_osc_enable = sec_osc_q;
    assign core_halt = hold_q;
    assign prefetch_next = prefetch_q;
    assign sleep_as_nop = nop_q;
    assign core_resume = resume_q;
    assign branch_to_vector = branch_q;
    assign device_reset = dev_rst_q;
    assign wdt_reset = wdt_rst_q;
    assign master_clear_oe = master_clear_pin_n_oe_q;
    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [smc_pkg::OST_W-1:0] ost_age_q;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) ost_age_q <= '0;
        else ost_age_q <= (state_q == smc_pkg::ST_OST) ? ost_age_q + 1'b1 : '0;
    end
    sequence s_entry;
        state_q == smc_pkg::ST_RUN && sleep_exec && !wif.pend_any && !master_clear_pin_n_low;
    endsequence

    sequence s_wake;
        state_q == smc_pkg::ST_SLEEP && wake_evt && !master_clear_pin_n_low;
    endsequence

    property p_only_by_instr;
        @(posedge clock) disable iff (!rst_b)
        (state_q == smc_pkg::ST_SLEEP && $past(state_q) == smc_pkg::ST_RUN) |-> $past(sleep_exec);
    endproperty
    a_only_by_instr: assert property (p_only_by_instr) else $error("sleep without instruction"); // [R1]

    property p_entry_flags;
        @(posedge clock) disable iff (!rst_b)
        s_entry |=> !pd_n_q && to_n_q && !osc_en_q && hold_q && state_q == smc_pkg::ST_SLEEP;
    endproperty
    a_entry_flags: assert property (p_entry_flags) else $error("bad sleep entry state"); // [R3]

    property p_entry_wdt;
        @(posedge clock) disable iff (!rst_b)
        s_entry and (wdt_enable) |=> wdt_clr_q ##1 (!wdt_clr_q || $past(wake_evt));
    endproperty
    a_entry_wdt: assert property (p_entry_wdt) else $error("watchdog not cleared on entry"); // [R2]

    property p_nop;
        @(posedge clock) disable iff (!rst_b)
        (state_q == smc_pkg::ST_RUN && sleep_exec && wif.pend_any && !master_clear_pin_n_low)
        |=> nop_q && !wdt_clr_q && $stable(pd_n_q) && state_q == smc_pkg::ST_RUN;
    endproperty
    a_nop: assert property (p_nop) else $error("pending sleep not a no-op"); // [R19]

    property p_pin_hold;
        @(posedge clock) disable iff (!rst_b)
        (hold_q && $past(hold_q)) |-> $stable(pin_out_q) && $stable(pin_oe_q);
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin changed in sleep"); // [R5]

    property p_master_clear_pin_n_quiet;
        @(posedge clock) disable iff (!rst_b)
        wdt_rst_q |-> !master_clear_oe && !dev_rst_q;
    endproperty
    a_master_clear_pin_n_quiet: assert property (p_master_clear_pin_n_quiet) else $error("watchdog drove master clear"); // [R6]

    property p_wdt_wake;
        @(posedge clock) disable iff (!rst_b)
        (s_wake and (wdt_wake)) |=> !to_n_q && !wdt_rst_q && !dev_rst_q && wdt_clr_q;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake mishandled"); // [R9]

    property p_stay_asleep;
        @(posedge clock) disable iff (!rst_b)
        (state_q == smc_pkg::ST_SLEEP && !wake_evt && !master_clear_pin_n_low)
        |=> state_q == smc_pkg::ST_SLEEP && !osc_en_q;
    endproperty
    a_stay_asleep: assert property (p_stay_asleep) else $error("spurious wake"); // [R13]

    property p_ost_wait;
        @(posedge clock) disable iff (!rst_b || master_clear_pin_n_low)
        ((s_wake and (!osc_no_startup)) |=> (state_q == smc_pkg::ST_OST)[*8]) and
        (state_q == smc_pkg::ST_OST |=> (state_q == smc_pkg::ST_RESUME) ==
            (ost_age_q == smc_pkg::OST_W'(smc_pkg::OST_CYCLES)));
    endproperty
    a_ost_wait: assert property (p_ost_wait) else $error("start-up wait wrong"); // [R20]

    property p_branch;
        @(posedge clock) disable iff (!rst_b)
        (state_q == smc_pkg::ST_RESUME && !master_clear_pin_n_low)
        |=> resume_q && (branch_q == (irq_wake_q && $past(global_irq_enable)));
    endproperty
    a_branch: assert property (p_branch) else $error("resume branch wrong"); // [R14]

    property p_master_clear_pin_n_reset;
        @(posedge clock) disable iff (!rst_b)
        master_clear_pin_n_low |=> dev_rst_q && state_q == smc_pkg::ST_RUN && !hold_q && osc_en_q;
    endproperty
    a_master_clear_pin_n_reset: assert property (p_master_clear_pin_n_reset) else $error("master clear not reset"); // [R7]

endmodule : smc_sleep_ctrl
`default_nettype wire

// ---- smc_wdt_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Watchdog partner: counts while enabled, restarts on clear
// ------------------------------------------------------------
module smc_wdt_model #(
    parameter int LIMIT = 200
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic clear,
    output logic timeout
);
    logic [15:0] count_q;

    // Keeps counting in sleep, so a time-out can wake the controller
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= 16'h0000;
            timeout <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (clear || !enable) begin
                count_q <= 16'h0000;
            end else if (count_q == 16'(LIMIT - 1)) begin
                count_q <= 16'h0000;
                timeout <= 1'b1;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end
endmodule : smc_wdt_model
`default_nettype wire

// ---- sleep_mode_controller_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_controller_bench;
    logic clock, rst_b, sleep_exec, wdt_enable, wdt_timeout, master_clear_pin_n;
    logic global_irq_enable, osc_no_startup, sec_osc_request;
    logic [smc_pkg::NUM_SRC-1:0] irq_flag, irq_enable, irq_clock_free;
    logic [smc_pkg::NUM_PINS-1:0] pin_out_core, pin_oe_core, pin_out, pin_oe;
    logic power_down_flag_n, timeout_flag_n, watchdog_clear, main_osc_enable;
    logic sec_osc_enable, core_halt, prefetch_next, sleep_as_nop, core_resume;
    logic branch_to_vector, device_reset, wdt_reset, master_clear_oe;
    wire logic [2:0] mon;
    int failures, num_checks, k;

    assign mon = {device_reset, wdt_reset, core_resume};

    smc_sleep_ctrl i_dut (
        .clock, .rst_b, .sleep_exec, .wdt_enable, .wdt_timeout, .master_clear_pin_n,
        .global_irq_enable, .irq_flag, .irq_enable, .irq_clock_free, .osc_no_startup,
        .sec_osc_request, .pin_out_core, .pin_oe_core, .power_down_flag_n,
        .timeout_flag_n, .watchdog_clear, .main_osc_enable, .sec_osc_enable,
        .core_halt, .prefetch_next, .sleep_as_nop, .core_resume, .branch_to_vector,
        .device_reset, .wdt_reset, .master_clear_oe, .pin_out, .pin_oe
    );

    smc_wdt_model #(.LIMIT(200)) i_wdt (
        .clock, .rst_b, .enable(wdt_enable), .clear(watchdog_clear), .timeout(wdt_timeout)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc

    // One-cycle sleep instruction; returns in the first answer cycle
    task enter_sleep;
        sleep_exec = 1'b1;
        @(negedge clock);
        sleep_exec = 1'b0;
    endtask : enter_sleep

    task wait_bit(input int b, output int n);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (mon[b] !== 1'b1 && n < 3000);
    endtask : wait_bit

    task complete_run;
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        #80000;
        failures++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        sleep_exec = 1'b0;
        wdt_enable = 1'b0;
        master_clear_pin_n = 1'b1;
        global_irq_enable = 1'b0;
        osc_no_startup = 1'b0;
        sec_osc_request = 1'b0;
        irq_flag = 8'h00;
        irq_enable = 8'h00;
        irq_clock_free = 8'hFF;
        pin_out_core = 8'hA5;
        pin_oe_core = 8'h0F;
        repeat (6) @(negedge clock);
        rst_b = 1'b1;
        chk(power_down_flag_n, 1'b1);
        chk(timeout_flag_n, 1'b1);
        chk(main_osc_enable, 1'b1);
        cyc(3);
        chk(core_halt, 1'b0);
        chk(pin_out, 8'hA5);
        // Pending enabled interrupt turns sleep into a no-operation
        irq_flag = 8'h10;
        irq_enable = 8'h10;
        wdt_enable = 1'b1;
        enter_sleep();
        chk(sleep_as_nop, 1'b1);
        chk(prefetch_next, 1'b1);
        chk(watchdog_clear, 1'b0);
        chk(power_down_flag_n, 1'b1);
        chk(core_halt, 1'b0);
        irq_flag = 8'h00;
        irq_enable = 8'h00;
        // Watchdog wake without start-up wait
        osc_no_startup = 1'b1;
        cyc(1);
        enter_sleep();
        chk(watchdog_clear, 1'b1);
        chk(power_down_flag_n, 1'b0);
        chk(timeout_flag_n, 1'b1);
        chk(main_osc_enable, 1'b0);
        chk(core_halt, 1'b1);
        wait_bit(0, k);
        chk(8'(k >= 198 && k <= 204), 8'h01);
        chk(timeout_flag_n, 1'b0);
        chk(device_reset, 1'b0);
        chk(core_halt, 1'b0);
        // Watchdog time-out while running
        wait_bit(1, k);
        chk(wdt_reset, 1'b1);
        chk(master_clear_oe, 1'b0);
        wdt_enable = 1'b0;
        // Interrupt wake with start-up wait, global enable clear
        osc_no_startup = 1'b0;
        irq_clock_free = 8'hFD;
        irq_enable = 8'h03;
        cyc(1);
        enter_sleep();
        chk(timeout_flag_n, 1'b1);
        pin_out_core = 8'h3C;
        pin_oe_core = 8'hF0;
        sec_osc_request = 1'b1;
        irq_flag = 8'h02;
        cyc(6);
        chk(core_halt, 1'b1);
        chk(sec_osc_enable, 1'b1);
        chk(pin_out, 8'hA5);
        chk(pin_oe, 8'h0F);
        irq_flag = 8'h04;
        cyc(6);
        chk(core_halt, 1'b1);
        irq_flag = 8'h01;
        cyc(1);
        chk(watchdog_clear, 1'b1);
        chk(main_osc_enable, 1'b1);
        wait_bit(0, k);
        chk(8'(k >= 1024 && k <= 1026), 8'h01);
        chk(branch_to_vector, 1'b0);
        chk(core_halt, 1'b0);
        cyc(2);
        chk(pin_out, 8'h3C);
        irq_flag = 8'h00;
        // Every wake source, flag raised just after entry
        osc_no_startup = 1'b1;
        irq_clock_free = 8'hFF;
        for (int s = 0; s < 8; s++) begin
            irq_enable = 8'h01 << s;
            global_irq_enable = s[0];
            cyc(1);
            enter_sleep();
            irq_flag = 8'h01 << s;
            wait_bit(0, k);
            chk(8'(k <= 3), 8'h01);
            chk(branch_to_vector, s[0]);
            irq_flag = 8'h00;
        end
        // External master clear during sleep
        global_irq_enable = 1'b0;
        irq_enable = 8'h00;
        cyc(1);
        enter_sleep();
        master_clear_pin_n = 1'b0;
        cyc(2);
        chk(device_reset, 1'b1);
        chk(master_clear_oe, 1'b0);
        master_clear_pin_n = 1'b1;
        cyc(2);
        chk(device_reset, 1'b0);
        chk(core_halt, 1'b0);
        // Power-up reset in mid-run sets the power-down flag again
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        chk(power_down_flag_n, 1'b1);
        chk(main_osc_enable, 1'b1);
        cyc(2);
        chk(core_halt, 1'b0);
        complete_run();
    end
endmodule : sleep_mode_controller_bench
`default_nettype wire
